// ---- design/maf_top.sv ----
`timescale 1ns/10ps
`include "maf_map.svh"

// Function
// - count accepted from 2 to 100, default 10
// - stack depth equals configured count
// - enable bit, 0 off, 1 on, default on
// - enabled output is an average
// - moving type pushes readings in fifo order
// - each push discards the oldest reading
// - one averaged sample per new reading
// - stack starts empty, first reading fills all
// - true average once stack refilled
// - settings held per measurement function
// - only moving type, also the default
// - settings per channel, index starts at 1
module maf_top (
   // Clock and reset
   input wire logic clock_in,
   input wire logic nrst_in,
   // Register port
   input wire logic [`MAF_ADDR_W-1:0] reg_addr_in,
   input wire logic [`MAF_DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [`MAF_DATA_W-1:0] reg_rdata_out,
   // Raw readings
   input wire logic [`MAF_READ_W-1:0] rd_data_in,
   input wire logic rd_valid_in,
   output logic rd_ready_out,
   // Filtered readings
   output logic [`MAF_READ_W-1:0] flt_data_out,
   output logic flt_valid_out,
   output logic flt_true_out
);
   maf_stack_if stk ();
   maf_div_if dv ();

   maf_pkg::maf_cnt_t cnt_q [0:`MAF_NSLOT-1];
   logic en_q [0:`MAF_NSLOT-1];
   logic [1:0] type_q [0:`MAF_NSLOT-1];
   logic [1:0] sel_ch_q;
   logic [1:0] sel_fn_q;
   maf_pkg::maf_state_t st_q;
   maf_pkg::maf_state_t st_d;
   maf_pkg::maf_sum_t sum_q;
   maf_pkg::maf_sum_t sum_push;
   maf_pkg::maf_sum_t sum_prime;
   maf_pkg::maf_sum_t rd_ext;
   maf_pkg::maf_cnt_t fresh_q;
   maf_pkg::maf_read_t avg_q;
   logic out_valid_q;
   logic out_true_q;
   logic [`MAF_DATA_W-1:0] rdata_q;
   logic [`MAF_DATA_W-1:0] rdata_d;
   logic [2:0] act_slot;
   logic [2:0] acc_slot;
   maf_pkg::maf_cnt_t act_cnt;
   maf_pkg::maf_cnt_t new_cnt;
   logic act_en;
   logic filt_on;
   logic cfg_hit;
   logic act_wr;
   logic cnt_legal;
   logic sel_legal;
   logic sel_wr;
   logic flush;
   logic acc;

   // ==========================================
   // Active setting slot
   // channel and function index select slot
   always_comb begin
      if (sel_ch_q == `MAF_CH_LAST) begin
         act_slot = 3'h3 + {1'b0, sel_fn_q};
      end else begin
         act_slot = {1'b0, sel_fn_q};
      end
   end

   assign act_cnt = cnt_q[act_slot];
   assign act_en = en_q[act_slot];
   assign filt_on = act_en && (type_q[act_slot] == `MAF_TYPE_MOV);

   // ==========================================
   // Address decode
   assign cfg_hit = (reg_addr_in[1:0] == 2'h0) && (reg_addr_in < `MAF_OFS_CFG_END);
   assign acc_slot = reg_addr_in[4:2];
   assign new_cnt = reg_wdata_in[`MAF_CNT_W-1:0];
   assign cnt_legal = (new_cnt >= `MAF_CNT_MIN) && (new_cnt <= `MAF_CNT_MAX);
   assign act_wr = reg_wr_in && cfg_hit && (acc_slot == act_slot);
   assign sel_wr = reg_wr_in && (reg_addr_in == `MAF_OFS_SEL);
   assign sel_legal = (reg_wdata_in[1:0] != 2'h0) && (reg_wdata_in[1:0] <= `MAF_CH_LAST) &&
                      (reg_wdata_in[`MAF_SEL_FN_LSB+:2] <= `MAF_FN_LAST);

   always_comb begin
      flush = 1'b0;
      if (act_wr && cnt_legal && new_cnt != act_cnt) begin
         flush = 1'b1;
      end else if (act_wr && reg_wdata_in[`MAF_CFG_EN_BIT] != act_en) begin
         flush = 1'b1;
      end else if (sel_wr && sel_legal &&
                   ({reg_wdata_in[`MAF_SEL_FN_LSB+:2], reg_wdata_in[1:0]} !=
                    {sel_fn_q, sel_ch_q})) begin
         flush = 1'b1;
      end
   end

   // ==========================================
   // Per function settings
   // one slot per channel and function
   for (genvar i = 0; i < `MAF_NSLOT; i++) begin : g_slot
      localparam logic [2:0] SLOT = 3'(i);
      always_ff @(posedge clock_in or negedge nrst_in) begin
         if (!nrst_in) begin
            cnt_q[i] <= `MAF_CNT_RST;
            en_q[i] <= `MAF_EN_RST;
            type_q[i] <= `MAF_TYPE_MOV;
         end else if (reg_wr_in && cfg_hit && acc_slot == SLOT) begin
            if (cnt_legal) begin
               cnt_q[i] <= new_cnt;
            end
            en_q[i] <= reg_wdata_in[`MAF_CFG_EN_BIT];
            if (reg_wdata_in[`MAF_CFG_TYPE_LSB+:2] == `MAF_TYPE_MOV) begin
               type_q[i] <= `MAF_TYPE_MOV;
            end
         end
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sel_ch_q <= `MAF_SEL_CH_RST;
         sel_fn_q <= `MAF_SEL_FN_RST;
      end else if (sel_wr && sel_legal) begin
         sel_ch_q <= reg_wdata_in[1:0];
         sel_fn_q <= reg_wdata_in[`MAF_SEL_FN_LSB+:2];
      end
   end

   // ==========================================
   // Reading handshake and state
   assign rd_ready_out = (st_q != maf_pkg::MAF_S_BUSY) && !flush;
   assign acc = rd_valid_in && rd_ready_out;

   always_comb begin
      st_d = st_q;
      case (st_q)
         maf_pkg::MAF_S_EMPTY: begin
            if (acc && filt_on) begin
               st_d = maf_pkg::MAF_S_READY;
            end
         end
         maf_pkg::MAF_S_READY: begin
            if (acc) begin
               st_d = maf_pkg::MAF_S_BUSY;
            end
         end
         maf_pkg::MAF_S_BUSY: begin
            if (dv.done) begin
               st_d = maf_pkg::MAF_S_READY;
            end
         end
         default: begin
            st_d = maf_pkg::MAF_S_EMPTY;
         end
      endcase
      if (flush) begin
         st_d = maf_pkg::MAF_S_EMPTY;
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q <= maf_pkg::MAF_S_EMPTY;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================
   // Stack and running sum
   // first reading primes stack
   assign stk.prime = acc && filt_on && (st_q == maf_pkg::MAF_S_EMPTY);
   assign stk.push = acc && (st_q == maf_pkg::MAF_S_READY);
   assign stk.wdata = rd_data_in;
   assign stk.depth = act_cnt;

   assign rd_ext = {{(`MAF_SUM_W-`MAF_READ_W){rd_data_in[`MAF_READ_W-1]}}, rd_data_in};
   assign sum_prime = rd_ext * $signed({25'h0000000, act_cnt});
   assign sum_push = sum_q + rd_ext -
                     {{(`MAF_SUM_W-`MAF_READ_W){stk.oldest[`MAF_READ_W-1]}}, stk.oldest};

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sum_q <= 32'h00000000;
      end else if (stk.prime) begin
         sum_q <= sum_prime;
      end else if (stk.push) begin
         sum_q <= sum_push;
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         fresh_q <= 7'h00;
      end else if (flush || stk.prime) begin
         fresh_q <= 7'h00;
      end else if (stk.push && fresh_q < act_cnt) begin
         fresh_q <= fresh_q + 7'h01;
      end
   end

   assign dv.start = stk.push;
   assign dv.dividend = sum_push;
   assign dv.divisor = act_cnt;

   // ==========================================
   // Filtered output
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         avg_q <= 24'h000000;
         out_valid_q <= 1'b0;
         out_true_q <= 1'b0;
      end else begin
         out_valid_q <= 1'b0;
         if (acc && (!filt_on || st_q == maf_pkg::MAF_S_EMPTY)) begin
            avg_q <= rd_data_in;
            out_valid_q <= 1'b1;
            out_true_q <= 1'b0;
         end else if (dv.done && st_q == maf_pkg::MAF_S_BUSY && !flush) begin
            avg_q <= dv.quot;
            out_valid_q <= 1'b1;
            out_true_q <= (fresh_q == act_cnt);
         end
      end
   end

   assign flt_data_out = avg_q;
   assign flt_valid_out = out_valid_q;
   assign flt_true_out = out_true_q;

   // ==========================================
   // Register read
   always_comb begin
      rdata_d = 32'h00000000;
      if (cfg_hit) begin
         rdata_d = {18'h00000, type_q[acc_slot], 3'h0, en_q[acc_slot], 1'b0, cnt_q[acc_slot]};
      end else if (reg_addr_in == `MAF_OFS_SEL) begin
         rdata_d = {26'h0000000, sel_fn_q, 2'h0, sel_ch_q};
      end else if (reg_addr_in == `MAF_OFS_STAT) begin
         rdata_d = {21'h000000, dv.busy, (st_q != maf_pkg::MAF_S_EMPTY) && (fresh_q == act_cnt),
                    st_q != maf_pkg::MAF_S_EMPTY, 1'b0, fresh_q};
      end else if (reg_addr_in == `MAF_OFS_RES) begin
         rdata_d = {{(`MAF_DATA_W-`MAF_READ_W){avg_q[`MAF_READ_W-1]}}, avg_q};
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_q <= 32'h00000000;
      end else if (reg_rd_in) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 32'h00000000;
      end
   end

   assign reg_rdata_out = rdata_q;

   // ==========================================
   // Submodules
   maf_stack u_stack (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .stk(stk.stack)
   );

   maf_div u_div (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .dv(dv.div)
   );

   // ==========================================
   // Checks
   property p_cnt_range;
      @(posedge clock_in) disable iff (!nrst_in)
      (act_cnt >= `MAF_CNT_MIN) && (act_cnt <= `MAF_CNT_MAX);
   endproperty
   a_cnt_range: assert property (p_cnt_range) else $error("count out of range");

   property p_raw_pass;
      @(posedge clock_in) disable iff (!nrst_in)
      (acc && !filt_on) |=> (out_valid_q && !out_true_q && avg_q == $past(rd_data_in));
   endproperty
   a_raw_pass: assert property (p_raw_pass) else $error("raw reading not passed");

   property p_prime;
      @(posedge clock_in) disable iff (!nrst_in)
      stk.prime |=> (out_valid_q && avg_q == $past(rd_data_in) && st_q == maf_pkg::MAF_S_READY);
   endproperty
   a_prime: assert property (p_prime) else $error("first reading not output");

   property p_avg_out;
      @(posedge clock_in) disable iff (!nrst_in)
      stk.push |=> ##[0:40] (out_valid_q || st_q == maf_pkg::MAF_S_EMPTY);
   endproperty
   a_avg_out: assert property (p_avg_out) else $error("no sample after reading");

   property p_busy_stall;
      @(posedge clock_in) disable iff (!nrst_in)
      stk.push |=> (!rd_ready_out)[*8];
   endproperty
   a_busy_stall: assert property (p_busy_stall) else $error("reading taken while busy");

   property p_true_flag;
      @(posedge clock_in) disable iff (!nrst_in)
      (out_valid_q && out_true_q) |-> (fresh_q == act_cnt);
   endproperty
   a_true_flag: assert property (p_true_flag) else $error("true average too early");

   property p_flush;
      @(posedge clock_in) disable iff (!nrst_in)
      flush |=> (st_q == maf_pkg::MAF_S_EMPTY && fresh_q == 7'h00);
   endproperty
   a_flush: assert property (p_flush) else $error("stack not emptied");

   property p_sel_hold;
      @(posedge clock_in) disable iff (!nrst_in)
      (sel_wr && reg_wdata_in[1:0] == 2'h0) |=> (sel_ch_q == $past(sel_ch_q));
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("channel zero accepted");

   property p_type_mov;
      @(posedge clock_in) disable iff (!nrst_in)
      type_q[act_slot] == `MAF_TYPE_MOV;
   endproperty
   a_type_mov: assert property (p_type_mov) else $error("type not moving");
endmodule

// ---- design/maf_map.svh ----
`ifndef MAF_MAP_SVH
`define MAF_MAP_SVH

// ==========================================
// Widths and sizes
`define MAF_READ_W 24
`define MAF_SUM_W 32
`define MAF_CNT_W 7
`define MAF_DEPTH 100
`define MAF_NSLOT 6
`define MAF_ADDR_W 8
`define MAF_DATA_W 32

// ==========================================
// Reset values and limits
`define MAF_CNT_MIN 7'h02
`define MAF_CNT_MAX 7'h64
`define MAF_CNT_RST 7'h0A
`define MAF_EN_RST 1'b1
`define MAF_TYPE_MOV 2'h1
`define MAF_SEL_CH_RST 2'h1
`define MAF_SEL_FN_RST 2'h0
`define MAF_CH_LAST 2'h2
`define MAF_FN_LAST 2'h2

// ==========================================
// Register offsets
`define MAF_OFS_CFG 8'h00
`define MAF_OFS_CFG_END 8'h18
`define MAF_OFS_SEL 8'h20
`define MAF_OFS_STAT 8'h24
`define MAF_OFS_RES 8'h28

// ==========================================
// Field positions
`define MAF_CFG_EN_BIT 8
`define MAF_CFG_TYPE_LSB 12
`define MAF_SEL_FN_LSB 4

// ==========================================
// Timing counts
`define MAF_DIV_STEPS 6'h20

`endif

// ---- design/maf_pkg.sv ----
`include "maf_map.svh"

package maf_pkg;
   // ==========================================
   // Types
   typedef enum logic [2:0] {
      MAF_S_EMPTY = 3'b001,
      MAF_S_READY = 3'b010,
      MAF_S_BUSY = 3'b100
   } maf_state_t;
   typedef logic signed [`MAF_READ_W-1:0] maf_read_t;
   typedef logic signed [`MAF_SUM_W-1:0] maf_sum_t;
   typedef logic [`MAF_CNT_W-1:0] maf_cnt_t;
endpackage

// ---- design/maf_if.sv ----
`timescale 1ns/10ps
`include "maf_map.svh"

// ==========================================
// Stack access
interface maf_stack_if;
   logic prime;
   logic push;
   maf_pkg::maf_read_t wdata;
   maf_pkg::maf_cnt_t depth;
   maf_pkg::maf_read_t oldest;
   modport ctrl(output prime, push, wdata, depth, input oldest);
   modport stack(input prime, push, wdata, depth, output oldest);
endinterface

// ==========================================
// Divider access
interface maf_div_if;
   logic start;
   maf_pkg::maf_sum_t dividend;
   maf_pkg::maf_cnt_t divisor;
   logic busy;
   logic done;
   maf_pkg::maf_read_t quot;
   modport ctrl(output start, dividend, divisor, input busy, done, quot);
   modport div(input start, dividend, divisor, output busy, done, quot);
endinterface

// ---- design/maf_stack.sv ----
`timescale 1ns/10ps
`include "maf_map.svh"

module maf_stack (
   // Clock and reset
   input wire logic clock_in,
   input wire logic nrst_in,
   // Stack port
   maf_stack_if.stack stk
);
   maf_pkg::maf_read_t mem_q [0:`MAF_DEPTH-1];
   maf_pkg::maf_read_t fill_q;
   maf_pkg::maf_cnt_t ptr_q;
   logic [`MAF_DEPTH-1:0] stale_q;

   // ==========================================
   // Storage
   always_ff @(posedge clock_in) begin
      if (stk.push) begin
         mem_q[ptr_q] <= stk.wdata;
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ptr_q <= 7'h00;
      end else if (stk.prime) begin
         ptr_q <= 7'h00;
      end else if (stk.push) begin
         ptr_q <= (ptr_q == stk.depth - 7'h01) ? 7'h00 : ptr_q + 7'h01;
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         fill_q <= 24'h000000;
      end else if (stk.prime) begin
         fill_q <= stk.wdata;
      end
   end

   for (genvar i = 0; i < `MAF_DEPTH; i++) begin : g_stale
      localparam logic [`MAF_CNT_W-1:0] IDX = 7'(i);
      always_ff @(posedge clock_in or negedge nrst_in) begin
         if (!nrst_in) begin
            stale_q[i] <= 1'b1;
         end else if (stk.prime) begin
            stale_q[i] <= 1'b1;
         end else if (stk.push && ptr_q == IDX) begin
            stale_q[i] <= 1'b0;
         end
      end
   end

   assign stk.oldest = stale_q[ptr_q] ? fill_q : mem_q[ptr_q];

   // ==========================================
   // Checks
   property p_ptr_wrap;
      @(posedge clock_in) disable iff (!nrst_in)
      (stk.push && !stk.prime && ptr_q == stk.depth - 7'h01) |=> (ptr_q == 7'h00);
   endproperty
   a_ptr_wrap: assert property (p_ptr_wrap) else $error("stack pointer did not wrap");
endmodule

// ---- design/maf_div.sv ----
`timescale 1ns/10ps
`include "maf_map.svh"

module maf_div (
   // Clock and reset
   input wire logic clock_in,
   input wire logic nrst_in,
   // Divider port
   maf_div_if.div dv
);
   maf_pkg::maf_sum_t q_q;
   maf_pkg::maf_sum_t q_nx;
   maf_pkg::maf_cnt_t rem_q;
   logic [`MAF_CNT_W:0] rem_sh;
   logic [`MAF_CNT_W:0] rem_nx;
   logic neg_q;
   logic [5:0] step_q;
   logic busy_q;
   logic done_q;
   maf_pkg::maf_read_t quot_q;

   // ==========================================
   // Restoring step
   always_comb begin
      rem_sh = {rem_q, q_q[`MAF_SUM_W-1]};
      rem_nx = rem_sh;
      q_nx = {q_q[`MAF_SUM_W-2:0], 1'b0};
      if (rem_sh >= {1'b0, dv.divisor}) begin
         rem_nx = rem_sh - {1'b0, dv.divisor};
         q_nx = {q_q[`MAF_SUM_W-2:0], 1'b1};
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         neg_q <= 1'b0;
         q_q <= 32'h00000000;
         rem_q <= 7'h00;
         step_q <= 6'h00;
         quot_q <= 24'h000000;
      end else begin
         done_q <= 1'b0;
         if (dv.start) begin
            busy_q <= 1'b1;
            neg_q <= dv.dividend[`MAF_SUM_W-1];
            q_q <= dv.dividend[`MAF_SUM_W-1] ? -dv.dividend : dv.dividend;
            rem_q <= 7'h00;
            step_q <= 6'h00;
         end else if (busy_q) begin
            q_q <= q_nx;
            rem_q <= rem_nx[`MAF_CNT_W-1:0];
            step_q <= step_q + 6'h01;
            if (step_q == `MAF_DIV_STEPS - 6'h01) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
               quot_q <= neg_q ? -q_nx[`MAF_READ_W-1:0] : q_nx[`MAF_READ_W-1:0];
            end
         end
      end
   end

   assign dv.busy = busy_q;
   assign dv.done = done_q;
   assign dv.quot = quot_q;

   // ==========================================
   // Checks
   property p_div_len;
      @(posedge clock_in) disable iff (!nrst_in)
      dv.start ##1 (!dv.start)[*8] |-> busy_q && !done_q;
   endproperty
   a_div_len: assert property (p_div_len) else $error("divider ended early");
endmodule

// ---- verification/maf_conv.sv ----
`timescale 1ns/10ps
`include "maf_map.svh"

// ==========================================
// Reading source
module maf_conv (
   // Clock
   input wire logic clock_in,
   // Handshake
   input wire logic ready_in,
   output logic [`MAF_READ_W-1:0] data_out,
   output logic valid_out
);
   initial begin
      data_out = '0;
      valid_out = 1'b0;
   end
   // Holds the reading until the edge that takes it
   task automatic send(input maf_pkg::maf_read_t v);
      logic r;
      data_out <= v;
      valid_out <= 1'b1;
      forever begin
         @(negedge clock_in);
         r = ready_in;
         @(posedge clock_in);
         if (r === 1'b1) break;
      end
      valid_out <= 1'b0;
      data_out <= ~v;
   endtask
endmodule

// ---- verification/maf_top_tb.sv ----
`timescale 1ns/10ps
`include "maf_map.svh"

// ==========================================
// Bench
module maf_top_tb;
   logic clock_in;
   logic nrst_in;
   logic [`MAF_ADDR_W-1:0] a_q;
   logic [`MAF_DATA_W-1:0] wd_q;
   logic wr_q;
   logic rd_q;
   logic [`MAF_DATA_W-1:0] rdata;
   logic [`MAF_READ_W-1:0] rd_data;
   logic rd_valid;
   logic rd_ready;
   logic [`MAF_READ_W-1:0] flt_data;
   logic flt_valid;
   logic flt_true;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   int cnt = 10;
   bit en = 1;
   bit primed = 0;
   int fresh = 0;
   logic signed [`MAF_READ_W-1:0] stk[$];
   logic signed [`MAF_READ_W-1:0] last_e;

   maf_top maf_top_i (.clock_in(clock_in), .nrst_in(nrst_in), .reg_addr_in(a_q),
      .reg_wdata_in(wd_q), .reg_wr_in(wr_q), .reg_rd_in(rd_q), .reg_rdata_out(rdata),
      .rd_data_in(rd_data), .rd_valid_in(rd_valid), .rd_ready_out(rd_ready),
      .flt_data_out(flt_data), .flt_valid_out(flt_valid), .flt_true_out(flt_true));
   maf_conv maf_conv_i (.clock_in(clock_in), .ready_in(rd_ready), .data_out(rd_data),
      .valid_out(rd_valid));

   initial begin
      clock_in = 1'b0;
      forever #12.5 clock_in = ~clock_in;
   end
   initial begin
      nrst_in = 1'b0;
      a_q = '0;
      wd_q = '0;
      wr_q = 1'b0;
      rd_q = 1'b0;
   end
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end

   // ==========================================
   // Shared tasks
   task automatic results();
      $display("checks %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      a_q <= a;
      wd_q <= d;
      wr_q <= 1'b1;
      @(posedge clock_in);
      wr_q <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock_in);
      a_q <= a;
      rd_q <= 1'b1;
      @(posedge clock_in);
      rd_q <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic do_reset();
      @(posedge clock_in);
      nrst_in <= 1'b0;
      repeat (6) @(posedge clock_in);
      nrst_in <= 1'b1;
      cnt = 10;
      en = 1;
      primed = 0;
   endtask
   // Sends one reading, predicts the sample, checks value, flag and latency
   task automatic feed(input logic signed [`MAF_READ_W-1:0] v);
      logic signed [31:0] s;
      logic t;
      int lat;
      int n;
      logic r1;
      s = 0;
      r1 = 1'b0;
      t = 1'b0;
      lat = 1;
      if (!en) begin
         last_e = v;
      end else if (!primed) begin
         stk.delete();
         repeat (cnt) stk.push_back(v);
         primed = 1;
         fresh = 0;
         last_e = v;
      end else begin
         void'(stk.pop_front());
         stk.push_back(v);
         foreach (stk[i]) s += stk[i];
         last_e = `MAF_READ_W'(s / cnt);
         if (fresh < cnt) fresh++;
         t = (fresh == cnt);
         lat = 34;
      end
      @(posedge clock_in);
      maf_conv_i.send(v);
      n = 0;
      do begin
         @(negedge clock_in);
         n++;
         if (n == 1) r1 = rd_ready;
      end while (flt_valid !== 1'b1 && n < 40);
      chk(n, lat);
      chk({31'h0, r1}, {31'h0, lat == 1});
      chk({31'h0, rd_ready}, 32'h00000001);
      chk({8'h00, flt_data}, {8'h00, last_e});
      chk({31'h0, flt_true}, {31'h0, t});
      @(negedge clock_in);
      chk({31'h0, flt_valid}, 32'h00000000);
   endtask

   // ==========================================
   // Scenarios
   task automatic t_defaults();
      for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0000110A);
      rd(8'h20, 32'h00000001);
      rd(8'h30, 32'h00000000);
   endtask
   task automatic t_moving();
      feed(24'sd100);
      for (int i = 1; i <= 10; i++) feed(24'(i * 77 - 400));
      rd(8'h24, 32'h0000030A);
      rd(8'h28, {{8{last_e[23]}}, last_e});
   endtask
   task automatic t_count();
      wr(8'h00, 32'h00001101);
      wr(8'h00, 32'h00001165);
      rd(8'h00, 32'h0000110A);
      wr(8'h00, 32'h0000210A);
      rd(8'h00, 32'h0000110A);
      feed(24'sd5000);
      wr(8'h00, 32'h00001102);
      cnt = 2;
      primed = 0;
      for (int i = 0; i < 4; i++) feed(24'(-9 * i - 1));
      wr(8'h00, 32'h00001164);
      cnt = 100;
      primed = 0;
      for (int i = 0; i < 102; i++) feed(24'(i * 3001 - 150000));
      rd(8'h00, 32'h00001164);
   endtask
   task automatic t_disable();
      wr(8'h00, 32'h00001064);
      en = 0;
      primed = 0;
      for (int i = 0; i < 3; i++) feed(24'(i * 11 - 7));
      wr(8'h00, 32'h00001164);
      en = 1;
      feed(24'sd40);
      feed(24'sd140);
   endtask
   task automatic t_slots();
      wr(8'h0C, 32'h00001103);
      feed(24'sd240);
      wr(8'h20, 32'h00000003);
      rd(8'h20, 32'h00000001);
      wr(8'h20, 32'h00000002);
      cnt = 3;
      primed = 0;
      for (int i = 0; i < 4; i++) feed(24'(i * 1000 + 3));
      rd(8'h0C, 32'h00001103);
      rd(8'h00, 32'h00001164);
      wr(8'h20, 32'h00000000);
      wr(8'h20, 32'h00000031);
      rd(8'h20, 32'h00000002);
      wr(8'h20, 32'h00000021);
      cnt = 10;
      primed = 0;
      feed(24'sd500);
      feed(24'sd600);
      rd(8'h20, 32'h00000021);
   endtask

   initial begin
      do_reset();
      t_defaults();
      t_moving();
      t_count();
      t_disable();
      t_slots();
      do_reset();
      t_defaults();
      feed(24'sd77);
      results();
   end
endmodule
